/* File: src/cplmc_macrocell.sv */
// Purpose: One macrocell with its flip-flop, clocking, control terms and I/O.
// Assumes: Both documented clocks arrive as levels sampled on clk_sys.
// Notes:   The flip-flop advances on detected edges of the chosen clock.

`timescale 1ns/100ps

module cplmc_macrocell
    import cplmc_pkg::*;
#(
    parameter int unsigned TERM_INPUTS = TERM_INPUTS_DEF
) (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic                        sync_pin_clock,
    input  wire logic                        flexible_clock,
    input  wire logic                        flex_clock_logic,
    input  wire logic                        flex_clock_use_logic,
    input  wire logic                        clock_select,
    input  wire logic                        clock_edge,
    input  wire logic                        storage_mode,
    input  wire logic                        logic_in,
    input  wire logic                        preset_reset_disable,
    input  wire logic [TERM_INPUTS-1:0]      term_inputs,
    input  wire logic [NUM_TERMS-1:0][TERM_INPUTS-1:0] term_use,
    input  wire logic [NUM_TERMS-1:0]        term_is_sum,
    input  wire logic [2:0]                  oe_select,
    input  wire logic                        global_output_float_en,
    input  wire logic                        global_output_float_n,
    input  wire logic                        pin_in,
    output logic                             pin_out,
    output logic                             pin_oe,
    output logic                             macro_feedback,
    output logic                             pin_feedback
);

    // Refuse an oe code space or a term width the logic cannot serve.
    if (TERM_INPUTS < 1) begin : g_bad_inputs
        $error("TERM_INPUTS must be at least one.");
    end
    if (NUM_OE_TERMS > int'(OE_SEL_ALWAYS_ON)) begin : g_bad_oe
        $error("Output-enable term count exceeds the select code space.");
    end

    // Whole state of the macrocell.
    typedef struct packed {
        logic pin_clk_prev;
        logic flex_clk_prev;
        logic ff;
        logic oe;
        logic pin_fb;
    } cplmc_state_t;

    cplmc_state_t state;
    cplmc_state_t next_state;

    logic [NUM_TERMS-1:0] term_val;
    logic                 flex_src;
    logic                 pin_edge;
    logic                 flex_edge;
    logic                 active_edge;
    logic                 preset_act;
    logic                 reset_act;
    logic                 float_act;
    logic                 oe_sel_val;

    // Reports whether a sampled clock moved along the chosen edge.
    function automatic logic edge_seen(input logic cur,
                                       input logic prev,
                                       input logic falling);
        edge_seen = falling ? (prev & ~cur) : (cur & ~prev);
    endfunction : edge_seen

    // Six shared control terms built from the routed inputs.
    for (genvar t = 0; t < NUM_TERMS; t++) begin : g_term
        cplmc_term #(
            .WIDTH       (TERM_INPUTS)
        ) u_term (
            .term_in     (term_inputs),
            .term_use    (term_use[t]),
            .term_is_sum (term_is_sum[t]),
            .term_out    (term_val[t])
        );
    end

    // Clock source and edge detection for both clocks.
    always_comb begin
        // The pin clock is taken as supplied from outside.
        flex_src    = flex_clock_use_logic ? flex_clock_logic
                                           : flexible_clock;
        pin_edge    = edge_seen(sync_pin_clock, state.pin_clk_prev,
                                clock_edge);
        flex_edge   = edge_seen(flex_src, state.flex_clk_prev,
                                clock_edge);
        active_edge = (clock_select == CLK_SEL_FLEX) ? flex_edge
                                                     : pin_edge;
    end

    // Preset and reset from the first two terms, unless disabled.
    always_comb begin
        preset_act = ~preset_reset_disable
                     & term_val[TERM_PRESET];
        reset_act  = ~preset_reset_disable
                     & term_val[TERM_RESET];
    end

    // Output-enable source selection and global float override.
    always_comb begin
        float_act = global_output_float_en
                    & ~global_output_float_n;
        if (oe_select == OE_SEL_ALWAYS_ON) begin
            oe_sel_val = 1'h1;
        end else if (oe_select < OE_SEL_ALWAYS_ON) begin
            oe_sel_val = term_val[TERM_OE_BASE +
                                  int'(oe_select[1:0])];
        end else begin
            oe_sel_val = 1'h0;
        end
    end

    // Next-state logic for the flip-flop, buffer enable and feedback.
    always_comb begin
        next_state               = state;
        next_state.pin_clk_prev  = sync_pin_clock;
        next_state.flex_clk_prev = flex_src;
        // Reset wins over preset when both terms are high.
        if (reset_act) begin
            next_state.ff = 1'h0;
        end else if (preset_act) begin
            next_state.ff = 1'h1;
        end else if (active_edge) begin
            if (storage_mode == MODE_TOGGLE) begin
                next_state.ff = state.ff ^ logic_in;
            end else begin
                next_state.ff = logic_in;
            end
        end
        next_state.oe     = oe_sel_val & ~float_act;
        next_state.pin_fb = pin_in;
    end

    // State register; power-on reset clears the flip-flop.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state.pin_clk_prev  <= 1'h0;
            state.flex_clk_prev <= 1'h0;
            state.ff            <= FF_RESET_VALUE;
            state.oe            <= OE_RESET_VALUE;
            state.pin_fb        <= 1'h0;
        end else begin
            state <= next_state;
        end
    end

    // Outputs come straight from the state flip-flops.
    assign pin_out        = state.ff;
    assign macro_feedback = state.ff;
    assign pin_oe         = state.oe;
    assign pin_feedback   = state.pin_fb;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    // A plain edge with no preset or reset pending.
    sequence s_clean_edge;
        active_edge && !preset_act && !reset_act;
    endsequence

    // Power-on reset leaves the flip-flop at zero.
    a_power_on_zero: assert property (disable iff (1'b0)
        srst |=> !macro_feedback && !pin_out)
        else $error("Flip-flop not zero after reset.");

    // Data mode captures the input on an active edge.
    a_data_capture: assert property (
        s_clean_edge ##0 (storage_mode == MODE_DATA)
        |=> macro_feedback == $past(logic_in))
        else $error("Data mode did not capture its input.");

    // Toggle mode inverts on a high input and holds on a low one.
    a_toggle_step: assert property (
        s_clean_edge ##0 (storage_mode == MODE_TOGGLE)
        |=> macro_feedback == ($past(macro_feedback) ^ $past(logic_in)))
        else $error("Toggle mode stepped wrongly.");

    // Without an edge or a control term the flip-flop holds.
    a_hold_no_edge: assert property (
        !active_edge && !preset_act && !reset_act |=> $stable(macro_feedback))
        else $error("Flip-flop changed without an active edge.");

    // Rising-edge pin clock selection gives an edge in the same cycle a rise is first sampled.
    a_pin_rise_edge: assert property (
        (clock_select == CLK_SEL_PIN) && (clock_edge == EDGE_RISING)
        && !sync_pin_clock ##1 sync_pin_clock && $stable(clock_select)
        && $stable(clock_edge) |-> active_edge)
        else $error("Pin clock rise did not produce an edge.");

    // Reset term clears the flip-flop unless disabled.
    a_term_reset: assert property (
        reset_act |=> !macro_feedback)
        else $error("Reset term did not clear the flip-flop.");

    // Preset term sets the flip-flop when reset is idle.
    a_term_preset: assert property (
        preset_act && !reset_act |=> macro_feedback)
        else $error("Preset term did not set the flip-flop.");

    // Disabled preset and reset leave data capture untouched.
    a_pr_disabled: assert property (
        preset_reset_disable && active_edge && storage_mode == MODE_DATA
        |=> macro_feedback == $past(logic_in))
        else $error("Disabled control terms still acted.");

    // Global float held low forces the buffer off.
    a_global_float: assert property (
        float_act |=> !pin_oe)
        else $error("Global float did not tri-state the output.");

    // The always-on code enables the buffer while global float is idle.
    a_oe_fixed: assert property (
        !float_act && (oe_select == OE_SEL_ALWAYS_ON) |=> pin_oe)
        else $error("Always-on output was not enabled.");

    // Codes above the always-on code keep the buffer off.
    a_oe_off: assert property (
        (oe_select > OE_SEL_ALWAYS_ON) |=> !pin_oe)
        else $error("Always-off output was enabled.");

    // Term-driven enable follows the chosen term.
    a_oe_term: assert property (
        !float_act && (oe_select < OE_SEL_ALWAYS_ON)
        |=> pin_oe == $past(term_val[TERM_OE_BASE + int'(oe_select[1:0])]))
        else $error("Output enable did not follow its term.");

    // Pin feedback returns the pin level one cycle later.
    a_pin_feedback: assert property (
        1'b1 |=> pin_feedback == $past(pin_in))
        else $error("Pin feedback lost the pin value.");

endmodule : cplmc_macrocell

/* File: src/cplmc_pkg.sv */
// Purpose: Shared constants for the programmable macrocell block.
// Assumes: One system clock; all pins are sampled synchronously to it.
// Notes:   The list below summarises the behaviour that the block keeps.
//
// Contract
// - Flip-flop is configurable as data-capture or toggle type.
// - Flip-flop triggers on rising or falling edge, chosen per macrocell.
// - Flexible clock is either pin-driven or generated by a logic equation.
// - Two shared control terms drive the preset and reset of the flip-flop.
// - Preset and reset can be disabled, leaving the flip-flop unaffected.
// - Power-on reset leaves the flip-flop at logic zero.
// - Four further shared terms are selectable as output-enable source.
// - Output buffer may instead be permanently enabled or disabled.
// - Enabled global float pin held low tri-states every output.
// - Two feedbacks: macrocell value before buffer, pin value after it.
// - An input pin has its buffer off and feeds back through the pin path.
// - A pin used as input still leaves macrocell feedback available.
// - Each shared control term is configurable as sum or product term.

package cplmc_pkg;

    // Number of shared control terms and their roles.
    localparam int unsigned NUM_TERMS        = 6;
    localparam int unsigned TERM_PRESET      = 0;
    localparam int unsigned TERM_RESET       = 1;
    localparam int unsigned TERM_OE_BASE     = 2;
    localparam int unsigned NUM_OE_TERMS     = 4;

    // Default width of the routed input vector of a control term.
    localparam int unsigned TERM_INPUTS_DEF  = 36;

    // Output-enable source codes; codes below ALWAYS_ON pick a term.
    localparam logic [2:0]  OE_SEL_ALWAYS_ON  = 3'h4;
    localparam logic [2:0]  OE_SEL_ALWAYS_OFF = 3'h5;

    // Clock source selection codes.
    localparam logic        CLK_SEL_PIN      = 1'h0;
    localparam logic        CLK_SEL_FLEX     = 1'h1;

    // Edge selection codes.
    localparam logic        EDGE_RISING      = 1'h0;
    localparam logic        EDGE_FALLING     = 1'h1;

    // Storage mode codes.
    localparam logic        MODE_DATA        = 1'h0;
    localparam logic        MODE_TOGGLE      = 1'h1;

    // Value the flip-flop and output enable take at power-on reset.
    localparam logic        FF_RESET_VALUE   = 1'h0;
    localparam logic        OE_RESET_VALUE   = 1'h0;

endpackage : cplmc_pkg

/* File: src/cplmc_term.sv */
// Purpose: One shared control term, forming a sum or a product of inputs.
// Assumes: Pure combinational logic; the caller registers what it needs.
// Notes:   An empty product is one and an empty sum is zero.

`timescale 1ns/100ps

module cplmc_term #(
    parameter int unsigned WIDTH = 36
) (
    input  wire logic [WIDTH-1:0] term_in,
    input  wire logic [WIDTH-1:0] term_use,
    input  wire logic             term_is_sum,
    output logic                  term_out
);

    // Refuse a term with no inputs at all.
    if (WIDTH < 1) begin : g_bad_width
        $error("Control term width must be at least one.");
    end

    // Unused inputs are forced neutral for the chosen operator.
    always_comb begin
        if (term_is_sum) begin
            term_out = |(term_in & term_use);
        end else begin
            term_out = &(term_in | ~term_use);
        end
    end

endmodule : cplmc_term

/* File: test/cplmc_pin_model.sv */
// Purpose: Board side of one I/O pin: external driver and pull-up.
// Assumes: The bench chooses when the outside world drives the pin.
// Notes:   Contention resolves to unknown so that it cannot pass unseen.

`timescale 1ns/100ps

module cplmc_pin_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic ext_en,
    input  wire logic ext_val,
    output logic      pin_in
);
    // Resolves the shared wire; a free pin is held high by its pull-up.
    always_comb begin
        if (pin_oe && ext_en) begin
            pin_in = 1'hX;
        end else if (pin_oe) begin
            pin_in = pin_out;
        end else if (ext_en) begin
            pin_in = ext_val;
        end else begin
            pin_in = 1'h1;
        end
    end
endmodule : cplmc_pin_model

/* File: test/cplmc_macrocell_tb.sv */
// Purpose: Self-checking bench for one macrocell.
// Assumes: Inputs change on the falling edge of clk_sys.
// Notes:   Outputs are judged three cycles after each stimulus.

`timescale 1ns/100ps

module cplmc_macrocell_tb;
    import cplmc_pkg::*;
    localparam int unsigned TI = 8;
    logic clk_sys = 0, srst = 1, spc = 0, fck = 0, fcl = 0, ul = 0;
    logic cs = 0, ce = 0, sm = 0, li = 0, prd = 0, gfe = 0, gfn = 1;
    logic [TI-1:0] ti = '0;
    logic [NUM_TERMS-1:0][TI-1:0] tu = '0;
    logic [NUM_TERMS-1:0] ts = '1;
    logic [2:0] os = 3'h5;
    logic ext_en = 0, ext_val = 0, pin_in, pin_out, pin_oe, mfb, pfb;
    int bad_count = 0, compares = 0, cycles = 0;

`define CHK(a, e, m) begin compares++; if ((a) !== (e)) begin \
bad_count++; $display("mismatch %0t %s", $time, m); end end

    cplmc_macrocell #(.TERM_INPUTS(TI)) DUT (.clk_sys(clk_sys),
        .srst(srst), .sync_pin_clock(spc), .flexible_clock(fck),
        .flex_clock_logic(fcl), .flex_clock_use_logic(ul),
        .clock_select(cs), .clock_edge(ce), .storage_mode(sm),
        .logic_in(li), .preset_reset_disable(prd), .term_inputs(ti),
        .term_use(tu), .term_is_sum(ts), .oe_select(os),
        .global_output_float_en(gfe), .global_output_float_n(gfn),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .macro_feedback(mfb), .pin_feedback(pfb));
    cplmc_pin_model pm (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // Free-running system clock and a guard against hangs.
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (bad_count == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test

    task automatic w3();
        repeat (3) @(negedge clk_sys);
    endtask : w3

    // Moves one clock source to a level, then lets the flop settle.
    task automatic ck(input int s, input logic v);
        case (s)
            0: spc = v;
            1: fck = v;
            default: fcl = v;
        endcase
        w3();
    endtask : ck

    // Data capture on either chosen edge.
    task automatic t_data();
        li = 1; ck(0, 1); `CHK(mfb, 1'h1, "d rise")
        ck(0, 0); `CHK(mfb, 1'h1, "d fall ignored")
        li = 0; ck(0, 1); `CHK(mfb, 1'h0, "d rise 0")
        ce = EDGE_FALLING; li = 1; ck(0, 0);
        `CHK(mfb, 1'h1, "f fall")
        li = 0; ck(0, 1); `CHK(mfb, 1'h1, "f rise ignored")
        ck(0, 0); `CHK(pin_out, 1'h0, "f fall 0")
        ce = EDGE_RISING;
    endtask : t_data

    // Toggle mode inverts on high input and holds on low input.
    task automatic t_toggle();
        sm = MODE_TOGGLE; li = 1;
        ck(0, 1); `CHK(mfb, 1'h1, "t first")
        ck(0, 0); ck(0, 1); `CHK(mfb, 1'h0, "t second")
        li = 0; ck(0, 0); ck(0, 1); `CHK(mfb, 1'h0, "t hold")
        ck(0, 0); sm = MODE_DATA;
    endtask : t_toggle

    // Flexible clock from its pin and from logic.
    task automatic t_flex();
        cs = CLK_SEL_FLEX; li = 1;
        ck(0, 1); `CHK(mfb, 1'h0, "pin clk unused")
        ck(0, 0); ck(1, 1); `CHK(mfb, 1'h1, "flex pin")
        ck(1, 0); li = 0; ul = 1;
        ck(1, 1); `CHK(mfb, 1'h1, "flex pin unused")
        ck(1, 0); ck(2, 1); `CHK(mfb, 1'h0, "flex logic")
        ck(2, 0); cs = CLK_SEL_PIN; ul = 0;
    endtask : t_flex

    // Preset and reset terms, product and sum forms, and disable.
    task automatic t_prs();
        tu[TERM_PRESET] = 8'h03; ts[TERM_PRESET] = 1'h0;
        tu[TERM_RESET] = 8'h04;
        ti = 8'h01; w3(); `CHK(mfb, 1'h0, "product half")
        ti = 8'h03; w3(); `CHK(mfb, 1'h1, "preset")
        ti = 8'h07; w3(); `CHK(mfb, 1'h0, "reset wins")
        prd = 1; ti = 8'h03; ck(0, 1); ck(0, 0);
        `CHK(mfb, 1'h0, "preset off")
        prd = 0; w3(); prd = 1; ti = 8'h04; li = 1; ck(0, 1); ck(0, 0);
        `CHK(mfb, 1'h1, "reset off")
        prd = 0; li = 0; w3(); `CHK(mfb, 1'h0, "reset on")
        ti = 8'h00; ts[TERM_PRESET] = 1'h1; w3();
    endtask : t_prs

    // Every enable source, then the global float pin.
    task automatic t_oe();
        for (int k = 0; k < 4; k++) begin
            tu[TERM_OE_BASE + k] = 8'h01 << (k + 2);
            os = 3'(k); ti = 8'h00; w3();
            `CHK(pin_oe, 1'h0, "oe term low")
            ti = 8'h01 << (k + 2); w3();
            `CHK(pin_oe, 1'h1, "oe term high")
        end
        ti = 8'h00;
        for (int k = 4; k < 8; k++) begin
            os = 3'(k); w3();
            `CHK(pin_oe, 1'(k == 4), "oe fixed")
        end
        os = OE_SEL_ALWAYS_ON; gfe = 1; gfn = 0; w3();
        `CHK(pin_oe, 1'h0, "float")
        gfe = 0; w3(); `CHK(pin_oe, 1'h1, "float off")
        gfe = 1; gfn = 1; w3(); `CHK(pin_oe, 1'h1, "float high")
        gfe = 0; os = OE_SEL_ALWAYS_OFF; w3();
    endtask : t_oe

    // Both feedback paths with the pin as input and as output.
    task automatic t_fb();
        li = 1; ck(0, 1); ck(0, 0); ext_en = 1; ext_val = 0; w3();
        `CHK(pfb, 1'h0, "pin fb 0")
        `CHK(mfb, 1'h1, "buried fb")
        ext_val = 1; w3(); `CHK(pfb, 1'h1, "pin fb 1")
        ext_en = 0; os = OE_SEL_ALWAYS_ON; li = 0; ck(0, 1); ck(0, 0);
        `CHK(pfb, 1'h0, "pin fb out")
        `CHK(mfb, 1'h0, "macro fb out")
    endtask : t_fb

    // Reset, then every scenario in turn.
    initial begin
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(mfb, FF_RESET_VALUE, "reset ff")
        `CHK(pin_oe, OE_RESET_VALUE, "reset oe")
        srst = 0; w3();
        t_data(); t_toggle(); t_flex(); t_prs(); t_oe(); t_fb();
        stop_test();
    end
endmodule : cplmc_macrocell_tb
